// ---- include/ctr_map.vh ----
/*
 * register offsets, field positions, reset values and timing counts
 * for the charger thermal and charge-current register pair.
 * assumes: included by the register bank and its deglitch filter.
 */
`ifndef CTR_MAP_VH
`define CTR_MAP_VH

// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define CTR_ADDR_THERMAL 8'h02
`define CTR_ADDR_FASTCHG 8'h03

// ----------------------------------------------------------------
// thermal control and masks fields
// ----------------------------------------------------------------
`define CTR_TH_SENSE_EN_BIT 7
`define CTR_TH_FAULT_HI_BIT 6
`define CTR_TH_FAULT_LO_BIT 5
`define CTR_TH_INT_FUNC_BIT 3
`define CTR_TH_WAKE_M_BIT 2
`define CTR_TH_RESET_M_BIT 1
`define CTR_TH_TIMER_M_BIT 0
`define CTR_TH_RESET 8'h88

// ----------------------------------------------------------------
// fast charge control fields
// ----------------------------------------------------------------
`define CTR_FC_RANGE_BIT 7
`define CTR_FC_CODE_HI 6
`define CTR_FC_CODE_LO 2
`define CTR_FC_DISABLE_BIT 1
`define CTR_FC_HIZ_BIT 0
`define CTR_FC_RESET 8'h14

// ----------------------------------------------------------------
// charge current scales, in mA
// ----------------------------------------------------------------
`define CTR_LO_BASE_MA 9'h005
`define CTR_LO_STEP_MA 9'h001
`define CTR_HI_BASE_MA 9'h028
`define CTR_HI_STEP_MA 9'h00A
`define CTR_LO_MAX_CODE 5'h1E
`define CTR_HI_MAX_CODE 5'h1A
`define CTR_EXT_CODE 5'h1F

// ----------------------------------------------------------------
// temperature fault codes
// ----------------------------------------------------------------
`define CTR_TF_NONE 2'h0
`define CTR_TF_COLD_HOT 2'h1
`define CTR_TF_COOL 2'h2
`define CTR_TF_WARM 2'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CTR_CLK_PERIOD_NS 10
`define CTR_DGL_TIME_US 1000
`define CTR_DGL_CYCLES ((`CTR_DGL_TIME_US * 1000) / `CTR_CLK_PERIOD_NS)

`endif

// ---- core/ctr_deglitch.v ----
/*
 * deglitch filter for the two-bit temperature fault code.
 * assumes: raw code synchronous to clk_i; count_en_i gates counting.
 */
`include "ctr_map.vh"

module ctr_deglitch #(
    parameter DGL_CYCLES = `CTR_DGL_CYCLES
) (
    // clock and reset
    input wire clk_i,
    input wire sys_rst_i,
    // control
    input wire count_en_i,
    input wire [1:0] raw_i,
    // filtered code
    output reg [1:0] code_o
);

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    reg [19:0] cnt_r;
    reg [1:0] last_r;

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_r <= 20'h00000;
            last_r <= 2'h0;
            code_o <= 2'h0;
        end else begin
            last_r <= raw_i;
            if (raw_i == code_o || raw_i != last_r) begin
                cnt_r <= 20'h00000;
            end else if (count_en_i) begin
                if (cnt_r >= DGL_CYCLES[19:0] - 20'h00001) begin
                    code_o <= raw_i;
                    cnt_r <= 20'h00000;
                end else begin
                    cnt_r <= cnt_r + 20'h00001;
                end
            end
        end
    end

endmodule // ctr_deglitch

// ---- core/ctr_regs.v ----
/*
 * thermal control / masks and fast charge control registers.
 * assumes: a serial-bus engine outside presents decoded byte
 * accesses as one-cycle read and write strobes.
 */
// Function
// - sense enable at bit 7, read/write, resets to 1, gates sensing.
// - read-only two-bit temperature fault code: none, cold/hot, cool, warm.
// - bit 3 resets to 1; clear means interrupt shows faults only; here unmasked wake and manual reset events still pulse it.
// - bit 2 set masks the wake interrupt from the manual reset input.
// - bit 1 masks only the reset interrupt; reset output still asserts.
// - bit 0 set masks the safety timer fault interrupt.
// - deglitch stops in high-impedance; clearing needs battery with bus or input power.
// - range bit 7 picks 1 mA steps from 5 or 10 mA steps from 40.
// - current is base plus five-bit code times step.
// - written codes past 35 or 300 mA clamp; code 11111 selects external.
// - charger disable bit resets to 0; 1 disables the charger.
// - high-impedance bit resets to 0; 1 enters high-impedance mode.
// - external resistor pin setting may supersede the default current.
// - thermal register sits at 0x02, reset pattern 1xxx 1000.
`include "ctr_map.vh"

module ctr_regs #(
    parameter DGL_CYCLES = `CTR_DGL_CYCLES
) (
    // clock and reset
    input wire clk_i,
    input wire sys_rst_i,
    // register access
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    // analog status
    input wire [1:0] temp_fault_raw_i,
    input wire vin_present_i,
    input wire bat_active_i,
    // interrupt sources
    input wire fault_event_i,
    input wire charge_status_event_i,
    input wire wake_event_i,
    input wire mr_reset_event_i,
    input wire timer_fault_event_i,
    // controls out
    output wire temp_sense_enable_o,
    output wire [1:0] temp_fault_code_o,
    output wire charge_current_range_o,
    output wire [4:0] charge_current_code_o,
    output reg [8:0] charge_current_ma_o,
    output wire use_charge_current_pin_o,
    output wire charger_disable_o,
    output wire high_impedance_select_o,
    output wire deglitch_run_o,
    output reg int_pulse_o,
    output reg reset_out_o
);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function [4:0] clamp_code;
        input range;
        input [4:0] code;
        begin
            if (code == `CTR_EXT_CODE) begin
                clamp_code = code;
            end else if (!range && code > `CTR_LO_MAX_CODE) begin
                clamp_code = `CTR_LO_MAX_CODE;
            end else if (range && code > `CTR_HI_MAX_CODE) begin
                clamp_code = `CTR_HI_MAX_CODE;
            end else begin
                clamp_code = code;
            end
        end
    endfunction

    function [8:0] current_ma;
        input range;
        input [4:0] code;
        reg [8:0] c9;
        begin
            c9 = {4'h0, code};
            if (range) begin
                current_ma = `CTR_HI_BASE_MA + c9 * `CTR_HI_STEP_MA;
            end else begin
                current_ma = `CTR_LO_BASE_MA + c9 * `CTR_LO_STEP_MA;
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    reg sense_en_r;
    reg int_func_r;
    reg wake_m_r;
    reg reset_m_r;
    reg timer_m_r;
    reg range_r;
    reg [4:0] code_r;
    reg disable_r;
    reg hiz_r;
    wire wr_th;
    wire wr_fc;
    wire [4:0] wcode;

    localparam [7:0] TH_RST = `CTR_TH_RESET;
    localparam [7:0] FC_RST = `CTR_FC_RESET;

    assign wr_th = reg_wr_i && (reg_addr_i == `CTR_ADDR_THERMAL);
    assign wr_fc = reg_wr_i && (reg_addr_i == `CTR_ADDR_FASTCHG);
    assign wcode = reg_wdata_i[`CTR_FC_CODE_HI:`CTR_FC_CODE_LO];

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            sense_en_r <= TH_RST[`CTR_TH_SENSE_EN_BIT];
            int_func_r <= TH_RST[`CTR_TH_INT_FUNC_BIT];
            wake_m_r <= TH_RST[`CTR_TH_WAKE_M_BIT];
            reset_m_r <= TH_RST[`CTR_TH_RESET_M_BIT];
            timer_m_r <= TH_RST[`CTR_TH_TIMER_M_BIT];
            range_r <= FC_RST[`CTR_FC_RANGE_BIT];
            code_r <= FC_RST[`CTR_FC_CODE_HI:`CTR_FC_CODE_LO];
            disable_r <= FC_RST[`CTR_FC_DISABLE_BIT];
            hiz_r <= FC_RST[`CTR_FC_HIZ_BIT];
        end else begin
            if (wr_th) begin
                // fault and reserved bits are not stored
                sense_en_r <= reg_wdata_i[`CTR_TH_SENSE_EN_BIT];
                int_func_r <= reg_wdata_i[`CTR_TH_INT_FUNC_BIT];
                wake_m_r <= reg_wdata_i[`CTR_TH_WAKE_M_BIT];
                reset_m_r <= reg_wdata_i[`CTR_TH_RESET_M_BIT];
                timer_m_r <= reg_wdata_i[`CTR_TH_TIMER_M_BIT];
            end
            if (wr_fc) begin
                range_r <= reg_wdata_i[`CTR_FC_RANGE_BIT];
                code_r <= clamp_code(reg_wdata_i[`CTR_FC_RANGE_BIT], wcode);
                disable_r <= reg_wdata_i[`CTR_FC_DISABLE_BIT];
                hiz_r <= reg_wdata_i[`CTR_FC_HIZ_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // temperature fault deglitch
    // ----------------------------------------------------------------
    wire [1:0] raw_gated;
    wire [1:0] fault_code;
    reg [1:0] fault_prev_r;

    // sensing off forces the no-fault code
    assign raw_gated = sense_en_r ? temp_fault_raw_i : `CTR_TF_NONE;
    // no counting in high impedance; otherwise input power, or battery during a bus access
    assign deglitch_run_o = !hiz_r && (vin_present_i || (bat_active_i && (reg_wr_i || reg_rd_i)));

    ctr_deglitch #(
        .DGL_CYCLES(DGL_CYCLES)
    ) u_deglitch (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .count_en_i(deglitch_run_o),
        .raw_i(raw_gated),
        .code_o(fault_code)
    );

    // ----------------------------------------------------------------
    // interrupt and reset output
    // ----------------------------------------------------------------
    wire temp_fault_new;

    assign temp_fault_new = (fault_code != fault_prev_r) && (fault_code != `CTR_TF_NONE);

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            fault_prev_r <= 2'h0;
            int_pulse_o <= 1'b0;
            reset_out_o <= 1'b0;
        end else begin
            fault_prev_r <= fault_code;
            int_pulse_o <= fault_event_i || temp_fault_new
                || (int_func_r && charge_status_event_i)
                || (wake_event_i && !wake_m_r)
                || (mr_reset_event_i && !reset_m_r)
                || (timer_fault_event_i && !timer_m_r);
            reset_out_o <= mr_reset_event_i;
        end
    end

    // ----------------------------------------------------------------
    // charge current
    // ----------------------------------------------------------------
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            charge_current_ma_o <= current_ma(FC_RST[`CTR_FC_RANGE_BIT],
                FC_RST[`CTR_FC_CODE_HI:`CTR_FC_CODE_LO]);
        end else begin
            charge_current_ma_o <= current_ma(range_r, code_r);
        end
    end

    assign use_charge_current_pin_o = (code_r == `CTR_EXT_CODE);
    assign temp_sense_enable_o = sense_en_r;
    assign temp_fault_code_o = fault_code;
    assign charge_current_range_o = range_r;
    assign charge_current_code_o = code_r;
    assign charger_disable_o = disable_r;
    assign high_impedance_select_o = hiz_r;

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            if (reg_addr_i == `CTR_ADDR_THERMAL) begin
                // fault bits live, reserved bit reads zero
                reg_rdata_o <= {sense_en_r, fault_code, 1'b0, int_func_r,
                    wake_m_r, reset_m_r, timer_m_r};
            end else if (reg_addr_i == `CTR_ADDR_FASTCHG) begin
                reg_rdata_o <= {range_r, code_r, disable_r, hiz_r};
            end else begin
                reg_rdata_o <= 8'h00;
            end
        end
    end

endmodule // ctr_regs

// ---- sim/ctr_host_model.sv ----
/* host model: byte reads and writes over the strobe port.
   assumes: strobes sampled on the rising clock edge. */
module ctr_host_model (
    // clock
    input wire clk_i,
    // register port
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    input wire [7:0] rdata_i
);
    timeunit 1ns;
    timeprecision 1ns;
    // termination setup lives outside this pair
    initial begin
        addr_o = 8'hFF;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        addr_o = ~a;
        d = rdata_i;
    endtask
endmodule // ctr_host_model

// ---- sim/ctr_regs_checker.sv ----
/* port checker for the register pair.
   assumes: bound to ctr_regs. */
module ctr_regs_checker #(
    parameter int DGL_CYCLES = 8
) (
    input wire clk_i,
    input wire sys_rst_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_rdata_o,
    input wire fault_event_i,
    input wire mr_reset_event_i,
    input wire charge_current_range_o,
    input wire [4:0] charge_current_code_o,
    input wire [8:0] charge_current_ma_o,
    input wire use_charge_current_pin_o,
    input wire charger_disable_o,
    input wire high_impedance_select_o,
    input wire [1:0] temp_fault_code_o,
    input wire deglitch_run_o,
    input wire int_pulse_o,
    input wire reset_out_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    chk_rdata_hold: assert property (
        !reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
    chk_reset_out: assert property (
        mr_reset_event_i |=> reset_out_o) else $error("reset out missing");
    chk_fault_int: assert property (
        fault_event_i |=> int_pulse_o) else $error("fault interrupt missing");
    chk_pin_select: assert property (
        use_charge_current_pin_o == (charge_current_code_o == 5'h1F)) else $error("pin select wrong");
    chk_code_clamp: assert property (
        use_charge_current_pin_o || charge_current_code_o <= (charge_current_range_o ? 5'h1A : 5'h1E))
        else $error("code not clamped");
    chk_ma_calc: assert property (
        1 |=> charge_current_ma_o == ($past(charge_current_range_o)
            ? 9'h028 + 9'h00A * {4'h0, $past(charge_current_code_o)}
            : 9'h005 + {4'h0, $past(charge_current_code_o)})) else $error("current wrong");
    chk_wr_fast: assert property (
        reg_wr_i && reg_addr_i == 8'h03 |=> {charge_current_range_o, charger_disable_o,
            high_impedance_select_o} == {$past(reg_wdata_i[7]), $past(reg_wdata_i[1:0])})
        else $error("fast charge write lost");
    chk_hiz_stop: assert property (
        high_impedance_select_o |-> !deglitch_run_o) else $error("deglitch runs in hiz");
    chk_hold_code: assert property (
        !deglitch_run_o |=> $stable(temp_fault_code_o)) else $error("fault code moved");
    cover property (use_charge_current_pin_o);
    cover property (int_pulse_o);
    cover property (deglitch_run_o ##1 $changed(temp_fault_code_o));
endmodule // ctr_regs_checker

bind ctr_regs ctr_regs_checker #(.DGL_CYCLES(DGL_CYCLES)) u_chk (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .fault_event_i(fault_event_i), .mr_reset_event_i(mr_reset_event_i),
    .charge_current_range_o(charge_current_range_o), .charge_current_code_o(charge_current_code_o),
    .charge_current_ma_o(charge_current_ma_o), .use_charge_current_pin_o(use_charge_current_pin_o),
    .charger_disable_o(charger_disable_o), .high_impedance_select_o(high_impedance_select_o),
    .temp_fault_code_o(temp_fault_code_o), .deglitch_run_o(deglitch_run_o),
    .int_pulse_o(int_pulse_o), .reset_out_o(reset_out_o));

// ---- sim/test_charger_thermal_and_charge_regs.sv ----
/* self-checking bench for the register pair.
   assumes: host model drives strobes, bench drives status. */
module test_charger_thermal_and_charge_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] addr, wdata, rdata, rd_v;
    logic wr, rd;
    logic [1:0] raw = 2'h0;
    logic vin = 1'b0;
    logic bat = 1'b0;
    logic [4:0] ev = 5'h00;
    wire [1:0] tcode;
    wire [4:0] code;
    wire [8:0] ma;
    wire ten, rng, pin, dis, hiz, run, irq, rso;
    int mismatches = 0;
    int checks = 0;
    logic [7:0] fw[4] = '{8'hEC, 8'h78, 8'hFF, 8'h83};
    logic [7:0] fr[4] = '{8'hE8, 8'h78, 8'hFF, 8'h83};
    logic [8:0] fm[4] = '{9'h12C, 9'h023, 9'h15E, 9'h028};
    logic [7:0] mk[2] = '{8'h08, 8'h07};
    always #5 clk_i = ~clk_i;
    ctr_host_model host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
        .rdata_i(rdata));
    ctr_regs #(.DGL_CYCLES(8)) DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .temp_fault_raw_i(raw), .vin_present_i(vin), .bat_active_i(bat),
        .fault_event_i(ev[4]), .charge_status_event_i(ev[3]), .wake_event_i(ev[2]),
        .mr_reset_event_i(ev[1]), .timer_fault_event_i(ev[0]), .temp_sense_enable_o(ten),
        .temp_fault_code_o(tcode), .charge_current_range_o(rng), .charge_current_code_o(code),
        .charge_current_ma_o(ma), .use_charge_current_pin_o(pin), .charger_disable_o(dis),
        .high_impedance_select_o(hiz), .deglitch_run_o(run), .int_pulse_o(irq), .reset_out_o(rso));
    task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, rd_v);
        cmp({1'b0, rd_v}, {1'b0, e});
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #20000;
        mismatches++;
        tally_and_finish;
    end
    initial begin
        repeat (6) @(negedge clk_i);
        sys_rst_i = 1'b0;
        rchk(8'h02, 8'h88);
        rchk(8'h03, 8'h14);
        cmp(ma, 9'h00A);
        rchk(8'h05, 8'h00);
        $display("test reset done");
        host.wr(8'h02, 8'hFF);
        rchk(8'h02, 8'h8F);
        cmp({8'h00, ten}, 9'h001);
        host.wr(8'h02, 8'h00);
        cmp({8'h00, ten}, 9'h000);
        $display("test thermal done");
        for (int i = 0; i < 4; i++) begin
            host.wr(8'h03, fw[i]);
            @(negedge clk_i);
            rchk(8'h03, fr[i]);
            cmp(ma, fm[i]);
            cmp({8'h00, pin}, {8'h00, fr[i][6:2] == 5'h1F});
        end
        cmp({7'h00, dis, hiz}, 9'h003);
        $display("test charge done");
        for (int j = 0; j < 2; j++) begin
            host.wr(8'h02, mk[j]);
            for (int k = 0; k < 5; k++) begin
                @(negedge clk_i);
                ev = 5'h01 << k;
                @(negedge clk_i);
                ev = 5'h00;
                cmp({7'h00, irq, rso}, {7'h00, k == 4 || (k == 3 ? mk[j][3] : !mk[j][k]), k == 1});
            end
        end
        $display("test interrupt done");
        vin = 1'b1;
        host.wr(8'h02, 8'h88);
        raw = 2'h1;
        repeat (30) @(negedge clk_i);
        cmp({7'h00, tcode}, 9'h000);
        host.wr(8'h03, 8'h14);
        for (int c = 1; c < 5; c++) begin
            raw = c[1:0];
            repeat (20) @(negedge clk_i);
            cmp({7'h00, tcode}, {7'h00, c[1:0]});
            rchk(8'h02, {1'b1, c[1:0], 5'h08});
        end
        raw = 2'h3;
        repeat (20) @(negedge clk_i);
        cmp({7'h00, tcode}, 9'h003);
        host.wr(8'h02, 8'h08);
        repeat (20) @(negedge clk_i);
        cmp({7'h00, tcode}, 9'h000);
        vin = 1'b0;
        bat = 1'b1;
        host.wr(8'h02, 8'h88);
        repeat (20) @(negedge clk_i);
        cmp({7'h00, tcode}, 9'h000);
        repeat (7) host.rd(8'h03, rd_v);
        cmp({7'h00, tcode}, 9'h000);
        host.rd(8'h03, rd_v);
        cmp({7'h00, tcode}, 9'h003);
        $display("test deglitch done");
        tally_and_finish;
    end
endmodule // test_charger_thermal_and_charge_regs
